// file: common/smc_params.svh
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH
`define NUM_CS 8
`define CS_W 3
`define ADDR_W 24
`define AXI_AW 8
`define AXI_CS_LSB 4
`define AXI_IDX_LSB 2
`define AXI_MAP_BIT 7
`define STATUS_ADDR 8'h80
`define OFS_SETUP 2'h0
`define OFS_PULSE 2'h1
`define OFS_CYCLE 2'h2
`define OFS_MODE 2'h3
`define SETUP_RST 32'h00000000
`define PULSE_RST 32'h01010101
`define CYCLE_RST 32'h00010001
`define MODE_RST 32'h00000003
`define MODE_RD_BIT 0
`define MODE_WR_BIT 1
`define FLD_WR_STROBE 0
`define FLD_CS_WR 8
`define FLD_RD_STROBE 16
`define FLD_CS_RD 24
`define FLD_WR_CYCLE 0
`define FLD_RD_CYCLE 16
`define SETUP_HI_SHIFT 7
`define PULSE_HI_SHIFT 8
`define CYCLE_HI_SHIFT 8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define GAP_CS 0
`define GAP_RLD 1
`define GAP_ER 2
`define GAP_RW 3
`endif

// file: common/smc_pkg.sv
`include "smc_params.svh"
package smc_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_GAP, ST_ACCESS, ST_HOLDX} seq_state_t;
	typedef logic [9:0] count_t;
	typedef struct packed {
		count_t rd_setup, cs_rd_setup, wr_setup, cs_wr_setup;
		count_t rd_pulse, cs_rd_pulse, wr_pulse, cs_wr_pulse;
		count_t rd_cycle, wr_cycle;
		logic read_mode, write_mode;
	} timing_t;

	function automatic count_t eff_setup(input logic [5:0] v);
		return (count_t'(v[5]) << `SETUP_HI_SHIFT) + count_t'(v[4:0]);
	endfunction : eff_setup

	function automatic count_t eff_pulse(input logic [6:0] v);
		return (count_t'(v[6]) << `PULSE_HI_SHIFT) + count_t'(v[5:0]);
	endfunction : eff_pulse

	function automatic count_t eff_cycle(input logic [8:0] v);
		return (count_t'(v[8:7]) << `CYCLE_HI_SHIFT) + count_t'(v[6:0]);
	endfunction : eff_cycle
endpackage : smc_pkg

// file: common/timing_if.sv
`timescale 1ns/1ps
`include "smc_params.svh"
interface timing_if;
	logic [`CS_W-1:0] sel_cs;
	logic [31:0] setup_w;
	logic [31:0] pulse_w;
	logic [31:0] cycle_w;
	logic [31:0] mode_w;
	smc_pkg::timing_t tim;
	modport bank(input sel_cs, output setup_w, pulse_w, cycle_w, mode_w);
	modport dec(input setup_w, pulse_w, cycle_w, mode_w, output tim);
	modport seq(output sel_cs, input tim);
endinterface : timing_if

// file: core/cfg_bank.sv
`timescale 1ns/1ps
`include "smc_params.svh"
module cfg_bank (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Software write port
	input wire logic wr_en,
	input wire logic [`CS_W-1:0] wr_cs,
	input wire logic [1:0] wr_idx,
	input wire logic [31:0] wr_data,
	input wire logic [3:0] wr_strb,
	input wire logic commit,
	// Software read port
	input wire logic [`CS_W-1:0] rd_cs,
	input wire logic [1:0] rd_idx,
	output logic [31:0] rd_data,
	// Committed set toward the sequencer
	timing_if.bank tif
);
	logic [31:0] live_r [`NUM_CS][4];
	logic [31:0] shadow_r [`NUM_CS][4];

	function automatic logic [31:0] rst_val(input int idx);
		unique case (idx)
			0: return `SETUP_RST;
			1: return `PULSE_RST;
			2: return `CYCLE_RST;
			default: return `MODE_RST;
		endcase
	endfunction : rst_val

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
			input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[b*8 +: 8] = n[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// Live words only reach the sequencer through commit, so a half-written set is never used
	always_ff @(posedge aclk) begin
		for (int c = 0; c < `NUM_CS; c++) begin
			for (int i = 0; i < 4; i++) begin
				if (!aresetn) begin
					live_r[c][i] <= rst_val(i);
					shadow_r[c][i] <= rst_val(i);
				end else begin
					if (wr_en && wr_cs == c[`CS_W-1:0] && wr_idx == i[1:0]) begin
						live_r[c][i] <= merge(live_r[c][i], wr_data, wr_strb);
					end
					if (commit) begin
						shadow_r[c][i] <= live_r[c][i];
					end
				end
			end
		end
	end

	assign rd_data = live_r[rd_cs][rd_idx];
	assign tif.setup_w = shadow_r[tif.sel_cs][`OFS_SETUP];
	assign tif.pulse_w = shadow_r[tif.sel_cs][`OFS_PULSE];
	assign tif.cycle_w = shadow_r[tif.sel_cs][`OFS_CYCLE];
	assign tif.mode_w = shadow_r[tif.sel_cs][`OFS_MODE];
endmodule : cfg_bank

// file: core/timing_decode.sv
`timescale 1ns/1ps
`include "smc_params.svh"
module timing_decode (
	// Raw committed words in, effective counts out
	timing_if.dec tif
);
	assign tif.tim.wr_setup = smc_pkg::eff_setup(tif.setup_w[`FLD_WR_STROBE +: 6]);
	assign tif.tim.cs_wr_setup = smc_pkg::eff_setup(tif.setup_w[`FLD_CS_WR +: 6]);
	assign tif.tim.rd_setup = smc_pkg::eff_setup(tif.setup_w[`FLD_RD_STROBE +: 6]);
	assign tif.tim.cs_rd_setup = smc_pkg::eff_setup(tif.setup_w[`FLD_CS_RD +: 6]);
	assign tif.tim.wr_pulse = smc_pkg::eff_pulse(tif.pulse_w[`FLD_WR_STROBE +: 7]);
	assign tif.tim.cs_wr_pulse = smc_pkg::eff_pulse(tif.pulse_w[`FLD_CS_WR +: 7]);
	assign tif.tim.rd_pulse = smc_pkg::eff_pulse(tif.pulse_w[`FLD_RD_STROBE +: 7]);
	assign tif.tim.cs_rd_pulse = smc_pkg::eff_pulse(tif.pulse_w[`FLD_CS_RD +: 7]);
	assign tif.tim.wr_cycle = smc_pkg::eff_cycle(tif.cycle_w[`FLD_WR_CYCLE +: 9]);
	assign tif.tim.rd_cycle = smc_pkg::eff_cycle(tif.cycle_w[`FLD_RD_CYCLE +: 9]);
	assign tif.tim.read_mode = tif.mode_w[`MODE_RD_BIT];
	assign tif.tim.write_mode = tif.mode_w[`MODE_WR_BIT];
endmodule : timing_decode

// file: core/static_mem_wait_state_timing.sv
// How it works
// - CS-controlled write drives data from CS setup
// - setup count is 128*top bit plus low five
// - pulse count is 256*top bit plus low six
// - cycle count is 256*top two plus low seven
// - per chip select setup, pulse, cycle registers
// - pulse register resets to 0x01010101
// - cycle register resets to 0x00010001
// - read and write modes reset to strobe control
// - zero-hold strobe write keeps address and select
// - one idle cycle between different chip selects
// - all controls inactive during chip-select idle
// - early-read idle only on same chip select
// - early-read idle on zero hold/setup conditions
// - stuck write strobe feedback adds early-read idle
// - reload idle loads committed parameter set
// - chip-select idle replaces reload on CS change
// - of register writes, only mode writes trigger reload
// - slow clock mode change also forces reload
// - read-to-write idle added on top of others
// - all counts per chip select in clocks
// - hold is cycle minus setup minus pulse
// - strobe-read captures on strobe rising edge
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "smc_params.svh"
module static_mem_wait_state_timing (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [`AXI_AW-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [`AXI_AW-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Access requests
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [`CS_W-1:0] req_cs,
	input wire logic [`ADDR_W-1:0] req_addr,
	input wire logic [31:0] req_wdata,
	input wire logic [3:0] req_be,
	output logic rd_valid,
	output logic [31:0] rd_data,
	// Slow clock mode level
	input wire logic slow_clk_mode,
	// External memory bus
	output logic [`ADDR_W-1:0] mem_addr,
	output logic [31:0] mem_wdata,
	output logic mem_data_oe,
	input wire logic [31:0] mem_rdata,
	output logic [`NUM_CS-1:0] chip_select_n,
	output logic read_strobe_n,
	output logic write_strobe_n,
	output logic [3:0] byte_select_n,
	output logic [3:0] byte_write_n,
	input wire logic write_strobe_fb_n
);
	typedef smc_pkg::count_t count_t;

	timing_if tif ();
	smc_pkg::timing_t tim;

	smc_pkg::seq_state_t state_r, state_nxt;
	logic [3:0] gap_r, gap_nxt;
	count_t left_r, left_nxt;
	logic [`CS_W-1:0] cur_cs_r;
	logic [`ADDR_W-1:0] addr_r;
	logic [31:0] wdat_r;
	logic [3:0] be_r;
	logic wr_r;
	logic have_prev_r, prev_wr_r, prev_nohold_r, prev_cs0_r, er_fb_r;
	logic cs_held_r;
	logic reload_pend_r;
	logic slow_s1_r, slow_s2_r, slow_prev_r;
	logic fb_s1_r, fb_s2_r;
	logic rd_valid_r;
	logic [31:0] rd_data_r;

	function automatic logic in_pulse(input count_t pos, input count_t s, input count_t p);
		return (pos >= s) && ({1'b0, pos} < ({1'b0, s} + {1'b0, p}));
	endfunction : in_pulse

	function automatic count_t last_pos(input count_t len);
		return (len == '0) ? '0 : count_t'(len - 1'b1);
	endfunction : last_pos

	// Hold of a signal is zero when setup plus pulse fills the cycle
	function automatic logic no_hold(input count_t s, input count_t p, input count_t len);
		return ({1'b0, s} + {1'b0, p}) >= {1'b0, len};
	endfunction : no_hold

	// Register bank and parameter decode
	logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
	logic [`AXI_AW-1:0] awaddr_r;
	logic [31:0] wdata_r, rdata_r, bank_rd;
	logic [3:0] wstrb_r;
	logic [1:0] bresp_r, rresp_r;
	wire do_wr = aw_hold_r && w_hold_r && !bvalid_r;
	wire wr_mapped = !awaddr_r[`AXI_MAP_BIT];
	wire wr_status = awaddr_r == `STATUS_ADDR;
	wire [`CS_W-1:0] wr_cs = awaddr_r[`AXI_CS_LSB +: `CS_W];
	wire [1:0] wr_idx = awaddr_r[`AXI_IDX_LSB +: 2];
	wire mode_write = do_wr && wr_mapped && wr_idx == `OFS_MODE && wstrb_r != 4'h0;
	wire ar_take = arvalid && arready;
	wire rd_mapped = !araddr[`AXI_MAP_BIT];
	wire rd_status = araddr == `STATUS_ADDR;
	wire commit;

	cfg_bank u_bank (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(do_wr && wr_mapped),
		.wr_cs(wr_cs),
		.wr_idx(wr_idx),
		.wr_data(wdata_r),
		.wr_strb(wstrb_r),
		.commit(commit),
		.rd_cs(araddr[`AXI_CS_LSB +: `CS_W]),
		.rd_idx(araddr[`AXI_IDX_LSB +: 2]),
		.rd_data(bank_rd),
		.tif(tif.bank)
	);

	timing_decode u_dec (
		.tif(tif.dec)
	);

	// Idle requests are judged against the incoming chip select's set
	assign tif.sel_cs = (state_r == smc_pkg::ST_IDLE) ? req_cs : cur_cs_r;
	assign tim = tif.tim;

	// AXI4-Lite slave: address and data taken in either order, one write at a time
	assign awready = !aw_hold_r && !bvalid_r;
	assign wready = !w_hold_r && !bvalid_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = !rvalid_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
		end else begin
			if (awvalid && awready) begin
				aw_hold_r <= 1'b1;
				awaddr_r <= awaddr;
			end else if (do_wr) begin
				aw_hold_r <= 1'b0;
			end
			if (wvalid && wready) begin
				w_hold_r <= 1'b1;
				wdata_r <= wdata;
				wstrb_r <= wstrb;
			end else if (do_wr) begin
				w_hold_r <= 1'b0;
			end
		end
	end

	// Status word is read-only; writes to it are answered but ignored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
		end else if (do_wr) begin
			bvalid_r <= 1'b1;
			bresp_r <= (wr_mapped || wr_status) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (bready) begin
			bvalid_r <= 1'b0;
		end
	end

	wire [31:0] status_word = {22'h000000, slow_s2_r, reload_pend_r, have_prev_r,
		state_r, cur_cs_r, wr_r, er_fb_r};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= `RESP_OKAY;
		end else if (ar_take) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_mapped ? bank_rd : (rd_status ? status_word : 32'h00000000);
			rresp_r <= (rd_mapped || rd_status) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// Pin synchronisers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slow_s1_r <= 1'b0;
			slow_s2_r <= 1'b0;
			slow_prev_r <= 1'b0;
			fb_s1_r <= 1'b1;
			fb_s2_r <= 1'b1;
		end else begin
			slow_s1_r <= slow_clk_mode;
			slow_s2_r <= slow_s1_r;
			slow_prev_r <= slow_s2_r;
			fb_s1_r <= write_strobe_fb_n;
			fb_s2_r <= fb_s1_r;
		end
	end

	// Reload request: a new event in the commit cycle keeps the flag set
	wire slow_change = slow_s2_r ^ slow_prev_r;
	// Taken at accept, so the idle cycle that follows already runs on the new set
	assign commit = req_valid && req_ready && reload_pend_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reload_pend_r <= 1'b0;
		end else if (mode_write || slow_change) begin
			reload_pend_r <= 1'b1;
		end else if (commit) begin
			reload_pend_r <= 1'b0;
		end
	end

	// Idle cycles owed before the next access
	wire accept = req_valid && req_ready;
	wire same_cs = have_prev_r && req_cs == cur_cs_r;
	wire rd_ctrl_setup0 = (tim.read_mode ? tim.rd_setup : tim.cs_rd_setup) == '0;
	wire er_zero = prev_nohold_r && rd_ctrl_setup0;
	wire er_cs = prev_cs0_r && tim.cs_rd_setup == '0;
	wire need_cs = have_prev_r && !same_cs;
	wire need_rld = reload_pend_r && !need_cs;
	wire need_er = same_cs && prev_wr_r && !req_write && (er_zero || er_cs || er_fb_r);
	wire need_rw = have_prev_r && !prev_wr_r && req_write;
	wire [3:0] gap_req = {need_rw, need_er, need_rld, need_cs};
	wire [3:0] gap_rest = gap_r & (gap_r - 4'h1);

	assign req_ready = state_r == smc_pkg::ST_IDLE;

	// Access position, counted down from the last cycle of the access
	wire count_t len = wr_r ? tim.wr_cycle : tim.rd_cycle;
	wire count_t len_new = req_write ? tim.wr_cycle : tim.rd_cycle;
	wire count_t pos = count_t'(last_pos(len) - left_r);
	wire in_acc = state_r == smc_pkg::ST_ACCESS;
	wire in_hx = state_r == smc_pkg::ST_HOLDX;
	wire acc_end = in_acc && left_r == '0;
	wire wr_nohold = no_hold(tim.wr_setup, tim.wr_pulse, tim.wr_cycle);
	wire cs_wr_nohold = no_hold(tim.cs_wr_setup, tim.cs_wr_pulse, tim.wr_cycle);
	wire need_hx = wr_r && tim.write_mode && wr_nohold;

	always_comb begin
		state_nxt = state_r;
		gap_nxt = gap_r;
		left_nxt = left_r;
		unique case (state_r)
			smc_pkg::ST_IDLE: begin
				if (accept) begin
					gap_nxt = gap_req;
					left_nxt = last_pos(len_new);
					state_nxt = (gap_req == 4'h0) ? smc_pkg::ST_ACCESS : smc_pkg::ST_GAP;
				end
			end
			smc_pkg::ST_GAP: begin
				gap_nxt = gap_rest;
				left_nxt = last_pos(len);
				if (gap_rest == 4'h0) begin
					state_nxt = smc_pkg::ST_ACCESS;
				end
			end
			smc_pkg::ST_ACCESS: begin
				if (acc_end) begin
					state_nxt = need_hx ? smc_pkg::ST_HOLDX : smc_pkg::ST_IDLE;
				end else begin
					left_nxt = count_t'(left_r - 1'b1);
				end
			end
			smc_pkg::ST_HOLDX: begin
				state_nxt = smc_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= smc_pkg::ST_IDLE;
			gap_r <= 4'h0;
			left_r <= '0;
		end else begin
			state_r <= state_nxt;
			gap_r <= gap_nxt;
			left_r <= left_nxt;
		end
	end

	// Latched request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cur_cs_r <= '0;
			addr_r <= '0;
			wdat_r <= '0;
			be_r <= 4'h0;
			wr_r <= 1'b0;
		end else if (accept) begin
			cur_cs_r <= req_cs;
			addr_r <= req_addr;
			wdat_r <= req_wdata;
			be_r <= req_be;
			wr_r <= req_write;
		end
	end

	wire cs_on = in_acc && (wr_r ? in_pulse(pos, tim.cs_wr_setup, tim.cs_wr_pulse)
		: in_pulse(pos, tim.cs_rd_setup, tim.cs_rd_pulse));
	// History of the finished access, used to judge the next one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			have_prev_r <= 1'b0;
			prev_wr_r <= 1'b0;
			prev_nohold_r <= 1'b0;
			prev_cs0_r <= 1'b0;
			er_fb_r <= 1'b0;
			cs_held_r <= 1'b0;
		end else if (acc_end) begin
			have_prev_r <= 1'b1;
			prev_wr_r <= wr_r;
			prev_nohold_r <= wr_r && (tim.write_mode ? wr_nohold : cs_wr_nohold);
			prev_cs0_r <= wr_r && !tim.write_mode && cs_wr_nohold;
			er_fb_r <= 1'b0;
			cs_held_r <= cs_on;
		end else if (in_hx) begin
			er_fb_r <= !fb_s2_r;
		end
	end

	// Strobe waveforms; outside an access and its extra hold cycle every line rests high
	wire rd_on = in_acc && !wr_r && in_pulse(pos, tim.rd_setup, tim.rd_pulse);
	wire wr_on = in_acc && wr_r && in_pulse(pos, tim.wr_setup, tim.wr_pulse);
	wire cs_drive = cs_on || (in_hx && cs_held_r);
	wire [`NUM_CS-1:0] cs_onehot = `NUM_CS'(1) << cur_cs_r;
	wire count_t data_from = tim.write_mode ? tim.wr_setup : tim.cs_wr_setup;
	wire count_t rd_edge = tim.read_mode ? count_t'(tim.rd_setup + tim.rd_pulse - 1'b1)
		: count_t'(tim.cs_rd_setup + tim.cs_rd_pulse - 1'b1);
	wire capture = in_acc && !wr_r && pos == rd_edge;

	assign chip_select_n = cs_drive ? ~cs_onehot : {`NUM_CS{1'b1}};
	assign read_strobe_n = !rd_on;
	assign write_strobe_n = !wr_on;
	assign byte_write_n = wr_on ? ~be_r : 4'hF;
	assign byte_select_n = (in_acc || in_hx) ? ~be_r : 4'hF;
	assign mem_addr = addr_r;
	assign mem_wdata = wdat_r;
	assign mem_data_oe = wr_r && ((in_acc && pos >= data_from) || in_hx);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_valid_r <= 1'b0;
			rd_data_r <= '0;
		end else begin
			rd_valid_r <= capture;
			if (capture) begin
				rd_data_r <= mem_rdata;
			end
		end
	end

	assign rd_valid = rd_valid_r;
	assign rd_data = rd_data_r;
endmodule : static_mem_wait_state_timing

// file: tb/timing_sva.sv
`timescale 1ns/1ps
`include "smc_params.svh"
module timing_sva (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus handshakes
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	// Access port
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic rd_valid,
	// Memory bus
	input wire logic mem_data_oe,
	input wire logic [`NUM_CS-1:0] chip_select_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic [3:0] byte_select_n,
	input wire logic [3:0] byte_write_n
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence bus_idle;
		byte_select_n == 4'hF;
	endsequence
	chk_write_resp: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
		else $error("write response not two edges after address and data");
	chk_b_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped before bready");
	chk_read_resp: assert property (arvalid && arready |=> rvalid)
		else $error("read response not one edge after address");
	chk_r_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read response dropped before rready");
	chk_req_busy: assert property (req_valid && req_ready |=> !req_ready)
		else $error("request port ready right after accept");
	chk_one_select: assert property ($onehot0(~chip_select_n))
		else $error("two chip selects active");
	chk_cs_gap: assert property (!(&chip_select_n) |=> (&chip_select_n) || $stable(chip_select_n))
		else $error("chip select changed without idle cycle");
	chk_gap_quiet: assert property (bus_idle |-> read_strobe_n && (&chip_select_n) &&
		byte_write_n == 4'hF)
		else $error("control line active in chip select idle cycle");
	chk_rd_capture: assert property ($rose(read_strobe_n) |-> ##[0:1] rd_valid)
		else $error("no read data after read strobe rose");
	chk_no_clash: assert property (!read_strobe_n |-> write_strobe_n && !mem_data_oe)
		else $error("data driven while read strobe active");
	chk_rw_gap: assert property ($rose(read_strobe_n) |-> (write_strobe_n && !mem_data_oe) [*2])
		else $error("write followed read with no idle cycle");
endmodule : timing_sva
bind static_mem_wait_state_timing timing_sva u_timing_sva (
	.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
	.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
	.arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready), .req_valid(req_valid),
	.req_ready(req_ready), .rd_valid(rd_valid), .mem_data_oe(mem_data_oe),
	.chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
	.write_strobe_n(write_strobe_n), .byte_select_n(byte_select_n), .byte_write_n(byte_write_n)
);

// file: tb/sram_model.sv
`timescale 1ns/1ps
`include "smc_params.svh"
module sram_model (
	// Bus from the controller
	input wire logic aclk,
	input wire logic [`ADDR_W-1:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic mem_data_oe,
	input wire logic [`NUM_CS-1:0] chip_select_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic [3:0] byte_select_n,
	// Answers
	output logic [31:0] mem_rdata,
	output logic write_strobe_fb_n,
	// Heavy load on the write strobe
	input wire logic slow_fb
);
	logic [31:0] mem [16];
	logic [31:0] last_r = 32'h0;
	logic [1:0] lag_r = 2'h0;
	wire sel = !(&chip_select_n);
	wire rd_on = sel && !read_strobe_n;
	initial for (int i = 0; i < 16; i++) mem[i] = 32'hC0DE0000 + 32'(i);
	// Released bus shows the inverse so a late capture cannot pass
	assign mem_rdata = rd_on ? mem[mem_addr[3:0]] : ~last_r;
	assign write_strobe_fb_n = write_strobe_n && lag_r == 2'h0;
	always @(posedge aclk) begin
		last_r <= mem_rdata;
		if (!write_strobe_n && slow_fb)
			lag_r <= 2'h2;
		else if (lag_r != 2'h0)
			lag_r <= lag_r - 2'h1;
		// Any driven cycle with a select stores the lanes, whichever signal controls the write
		if (sel && mem_data_oe)
			for (int b = 0; b < 4; b++)
				if (!byte_select_n[b])
					mem[mem_addr[3:0]][8*b +: 8] <= mem_wdata[8*b +: 8];
	end
endmodule : sram_model

// file: tb/static_mem_wait_state_timing_tb.sv
`timescale 1ns/1ps
`include "smc_params.svh"
module static_mem_wait_state_timing_tb;
	localparam int LIM = 2000;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic req_valid = 1'h0, req_write = 1'h0, slow_clk_mode = 1'h0, slow_fb = 1'h0;
	logic [`AXI_AW-1:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, req_wdata = 32'h0, rdata, rd_data, mem_wdata, mem_rdata;
	logic [3:0] wstrb = 4'h0, req_be = 4'hF, byte_select_n, byte_write_n;
	logic [`CS_W-1:0] req_cs = 3'h0;
	logic [`ADDR_W-1:0] req_addr = 24'h0, mem_addr;
	logic awready, wready, bvalid, arready, rvalid, req_ready, rd_valid, mem_data_oe;
	logic read_strobe_n, write_strobe_n, write_strobe_fb_n;
	logic [1:0] bresp, rresp;
	logic [`NUM_CS-1:0] chip_select_n;
	int n_fail = 0;
	int samples_checked = 0;
	static_mem_wait_state_timing u_static_mem_wait_state_timing (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_cs(req_cs),
		.req_addr(req_addr), .req_wdata(req_wdata), .req_be(req_be), .rd_valid(rd_valid),
		.rd_data(rd_data), .slow_clk_mode(slow_clk_mode), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_data_oe(mem_data_oe), .mem_rdata(mem_rdata),
		.chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
		.write_strobe_n(write_strobe_n), .byte_select_n(byte_select_n),
		.byte_write_n(byte_write_n), .write_strobe_fb_n(write_strobe_fb_n));
	sram_model u_sram_model (.aclk(aclk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_data_oe(mem_data_oe), .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
		.write_strobe_n(write_strobe_n), .byte_select_n(byte_select_n), .mem_rdata(mem_rdata),
		.write_strobe_fb_n(write_strobe_fb_n), .slow_fb(slow_fb));
	initial forever #10 aclk = ~aclk;

	task automatic give_verdict();
		if (n_fail == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp_word

	task automatic cmp_lat(input int got, input int exp);
		cmp_word(32'(got), 32'(exp));
	endtask : cmp_lat

	task automatic bound_chk(input int n);
		if (n >= LIM) begin
			n_fail++;
			give_verdict();
		end
	endtask : bound_chk

	function automatic logic [7:0] ra(input int cs, input int idx);
		return 8'(cs * 16 + idx * 4);
	endfunction : ra

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		logic ad, wd;
		n = 0;
		ad = 1'h0;
		wd = 1'h0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		while (!(ad && wd) && n < LIM) begin
			@(posedge aclk);
			n++;
			if (!ad && awready) begin
				awvalid <= 1'h0;
				ad = 1'h1;
			end
			if (!wd && wready) begin
				wvalid <= 1'h0;
				wd = 1'h1;
			end
		end
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
		end while (!bvalid && n < LIM);
		bready <= 1'h0;
		bound_chk(n);
		cmp_word({30'h0, bresp}, (a > 8'h80) ? 32'h2 : 32'h0);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
		end while (!arready && n < LIM);
		arvalid <= 1'h0;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
		end while (!rvalid && n < LIM);
		q = rdata;
		rready <= 1'h0;
		bound_chk(n);
		cmp_word({30'h0, rresp}, (a > 8'h80) ? 32'h2 : 32'h0);
	endtask : axi_rd

	task automatic acc(input logic w, input int cs, input int a, input logic [31:0] d,
		input logic [3:0] be, output int lr, output int ld, output logic [31:0] q);
		int n;
		n = 0;
		lr = 0;
		ld = 0;
		q = 32'h0;
		@(posedge aclk);
		req_valid <= 1'h1;
		req_write <= w;
		req_cs <= 3'(cs);
		req_addr <= 24'(a);
		req_wdata <= d;
		req_be <= be;
		do begin
			@(posedge aclk);
			n++;
		end while (!req_ready && n < LIM);
		req_valid <= 1'h0;
		for (int k = 1; k <= LIM && !(ld > 0 && (w || lr > 0)); k++) begin
			@(posedge aclk);
			n = k;
			if (rd_valid === 1'h1 && lr == 0) begin
				lr = k;
				q = rd_data;
			end
			if (req_ready === 1'h1 && ld == 0)
				ld = k;
		end
		bound_chk(n);
	endtask : acc

	task automatic rd_lat(input int cs, input int a, input int exp);
		int lr, ld;
		logic [31:0] q;
		acc(1'h0, cs, a, 32'h0, 4'hF, lr, ld, q);
		cmp_lat(lr, exp);
		cmp_word(q, 32'hC0DE0000 + 32'(a));
	endtask : rd_lat

	task automatic wr_rd(input int cs, input int a, input logic [31:0] d, input logic [3:0] be,
		input logic [31:0] exp);
		int lr, ld;
		logic [31:0] q;
		acc(1'h1, cs, a, d, be, lr, ld, q);
		acc(1'h0, cs, a, 32'h0, 4'hF, lr, ld, q);
		cmp_word(q, exp);
		cmp_lat(lr, 3);
	endtask : wr_rd

	task automatic t_regs();
		logic [31:0] q;
		logic [31:0] exp [4] = '{32'h0, 32'h01010101, 32'h00010001, 32'h3};
		for (int cs = 0; cs < 8; cs++)
			for (int i = 0; i < 4; i++) begin
				axi_rd(ra(cs, i), q);
				cmp_word(q, exp[i]);
			end
		axi_rd(8'h84, q);
		axi_wr(8'h84, 32'h3, 4'hF);
		axi_rd(8'h80, q);
		axi_wr(ra(6, 0), 32'hFFFFFF05, 4'h1);
		axi_rd(ra(6, 0), q);
		cmp_word(q, 32'h5);
	endtask : t_regs

	task automatic t_timing();
		rd_lat(0, 1, 2);
		rd_lat(0, 2, 2);
		rd_lat(1, 3, 3);
		axi_wr(ra(1, 1), 32'h01010101, 4'hF);
		rd_lat(1, 4, 2);
		axi_wr(ra(3, 3), 32'h3, 4'hF);
		rd_lat(1, 4, 3);
		axi_wr(ra(1, 3), 32'h3, 4'hF);
		rd_lat(2, 5, 3);
		slow_clk_mode <= 1'h1;
		repeat (4) @(posedge aclk);
		rd_lat(2, 5, 3);
	endtask : t_timing

	task automatic t_counts();
		int lr, ld;
		logic [31:0] q;
		// Setup and pulse sum stays within the cycle, no pulse is zero
		axi_wr(ra(4, 0), 32'h21210000, 4'hF);
		axi_wr(ra(4, 1), 32'h41410101, 4'hF);
		axi_wr(ra(4, 2), 32'h01830001, 4'hF);
		axi_wr(ra(4, 3), 32'h3, 4'hF);
		acc(1'h0, 4, 3, 32'h0, 4'hF, lr, ld, q);
		cmp_lat(lr, 1 + 129 + 257 + 1);
		cmp_lat(ld, 1 + 771 + 1);
		cmp_word(q, 32'hC0DE0003);
	endtask : t_counts

	task automatic t_writes();
		wr_rd(1, 5, 32'hA1B2C3D4, 4'hF, 32'hA1B2C3D4);
		slow_fb <= 1'h1;
		wr_rd(1, 6, 32'h5A5A0F0F, 4'h3, 32'hC0DE0F0F);
		slow_fb <= 1'h0;
		axi_wr(ra(5, 3), 32'h1, 4'hF);
		wr_rd(5, 7, 32'h13579BDF, 4'hF, 32'h13579BDF);
		wr_rd(5, 8, 32'h2468ACE0, 4'hC, 32'h24680008);
	endtask : t_writes

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		t_regs();
		t_timing();
		t_counts();
		t_writes();
		give_verdict();
	end
endmodule : static_mem_wait_state_timing_tb
